//--- rtl/eer_i2c_read.sv
// Two-wire serial memory slave: address load and random/sequential read
`timescale 1ns/100ps
`include "eer_cfg.svh"
module eer_i2c_read #(
   parameter int         MEM_DEPTH  = `EER_MEM_DEPTH,
   parameter int         FIFO_DEPTH = `EER_FIFO_DEPTH,
   parameter logic [6:0] DEV_ADDR   = `EER_DEV_ADDR
) (
   input  wire logic       ref_clk_i,
   input  wire logic       resetn_i,
   input  wire logic       ce_i,
   input  wire logic       link_clk_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   input  wire logic       pre_we_i,
   input  wire logic [7:0] pre_addr_i,
   input  wire logic [7:0] pre_data_i,
   output logic            sda_o,
   output logic            sda_oe_o
);
   localparam int            AW       = `EER_ADDR_W;
   localparam int            WW       = $bits(eer_pkg::eer_word_s);
   localparam logic [AW-1:0] ADDR_ONE = {{(AW-1){1'b0}}, 1'b1};

   eer_fifo_if #(.W(WW)) fq ();

   // ---------------- Reference-clock side: array and prefetch ----------------
   logic [AW-1:0] fetch_addr_r;
   logic [AW-1:0] tag_r;
   logic          pend_r;
   logic          mem_rd;
   logic [7:0]    mem_rdata;
   logic          msg_s1_r;
   logic          msg_s2_r;
   logic          msg_q_r;
   logic          msg_edge;

   // Link-side signals read across the crossing
   logic          msg_tgl_r;
   logic [AW-1:0] msg_addr_r;

   assign mem_rd     = ce_i && !pend_r;
   assign msg_edge   = msg_s2_r ^ msg_q_r;
   assign fq.w_valid = pend_r;
   assign fq.w_data  = {tag_r, mem_rdata};

   eer_mem #(
      .DEPTH (MEM_DEPTH),
      .AW    (AW)
   ) u_mem (
      .clk_i    (ref_clk_i),
      .resetn_i (resetn_i),
      .ce_i     (ce_i),
      .we_i     (pre_we_i),
      .waddr_i  (pre_addr_i),
      .wdata_i  (pre_data_i),
      .re_i     (mem_rd),
      .raddr_i  (fetch_addr_r),
      .rdata_o  (mem_rdata)
   );

   // Address update travels as a toggle; the word is held stable meanwhile
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         msg_s1_r <= 1'b0;
         msg_s2_r <= 1'b0;
         msg_q_r  <= 1'b0;
      end else if (ce_i) begin
         msg_s1_r <= msg_tgl_r;
         msg_s2_r <= msg_s1_r;
         msg_q_r  <= msg_s2_r;
      end
   end

   // Fetch pointer runs ahead of the bus; stale words are dropped by tag
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fetch_addr_r <= '0;
         tag_r        <= '0;
      end else if (ce_i) begin
         if (mem_rd) begin
            tag_r <= fetch_addr_r;
         end
         if (msg_edge) begin
            fetch_addr_r <= msg_addr_r;
         end else if (mem_rd) begin
            fetch_addr_r <= fetch_addr_r + ADDR_ONE;
         end
      end
   end

   // FIFO ready stalls the fetcher here
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pend_r <= 1'b0;
      end else if (ce_i) begin
         if (mem_rd) begin
            pend_r <= 1'b1;
         end else if (pend_r && fq.w_ready) begin
            pend_r <= 1'b0;
         end
      end
   end

   logic ce_s1_r;
   logic ce_s2_r;
   logic ce_l;

   eer_afifo #(
      .W     (WW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .wclk_i   (ref_clk_i),
      .rclk_i   (link_clk_i),
      .resetn_i (resetn_i),
      .wce_i    (ce_i),
      .rce_i    (ce_l),
      .q        (fq)
   );

   // ---------------- Link-clock side: bus engine ----------------
   logic                   scl_s1_r;
   logic                   scl_s2_r;
   logic                   scl_q_r;
   logic                   sda_s1_r;
   logic                   sda_s2_r;
   logic                   sda_q_r;
   logic                   scl_rise;
   logic                   scl_fall;
   logic                   start_det;
   logic                   stop_det;
   logic                   ev_ok;
   eer_pkg::eer_state_e    st_r;
   logic [2:0]             bit_cnt_r;
   logic [7:0]             sr_r;
   logic [7:0]             full_byte;
   logic [7:0]             tx_r;
   logic [AW-1:0]          addr_r;
   logic                   is_addr_r;
   logic                   rw_r;
   logic                   ack_on_r;
   logic                   oe_r;
   eer_pkg::eer_word_s     head;
   logic                   head_ok;
   logic                   step_now;
   logic [7:0]             load_byte;

   assign ce_l      = ce_s2_r;
   assign scl_rise  = scl_s2_r && !scl_q_r;
   assign scl_fall  = !scl_s2_r && scl_q_r;
   assign start_det = scl_s2_r && scl_q_r && sda_q_r && !sda_s2_r;
   assign stop_det  = scl_s2_r && scl_q_r && !sda_q_r && sda_s2_r;
   assign ev_ok     = ce_l && !start_det && !stop_det;
   assign full_byte = {sr_r[6:0], sda_s2_r};
   assign head      = fq.r_data;
   assign head_ok   = fq.r_valid && (head.tag == addr_r);
   assign load_byte = head_ok ? head.data : `EER_ERASED;
   // Head word retires only as the address steps, so an aborted byte can be resent
   assign step_now  = ev_ok && scl_fall && (st_r == eer_pkg::ST_REL);
   // Words not matching the live address are discarded at once
   assign fq.r_ready = ce_l && fq.r_valid && (!head_ok || step_now);
   assign sda_oe_o   = oe_r;

   always_ff @(posedge link_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ce_s1_r <= 1'b0;
         ce_s2_r <= 1'b0;
      end else begin
         ce_s1_r <= ce_i;
         ce_s2_r <= ce_s1_r;
      end
   end

   // Pins pass two flops; the third stage only serves edge detection
   always_ff @(posedge link_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         scl_q_r  <= 1'b1;
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
         sda_q_r  <= 1'b1;
      end else if (ce_l) begin
         scl_s1_r <= scl_i;
         scl_s2_r <= scl_s1_r;
         scl_q_r  <= scl_s2_r;
         sda_s1_r <= sda_i;
         sda_s2_r <= sda_s1_r;
         sda_q_r  <= sda_s2_r;
      end
   end

   // Open-drain: only the low level is ever driven
   always_ff @(posedge link_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sda_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
      end
   end

   always_ff @(posedge link_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_r       <= eer_pkg::ST_IDLE;
         bit_cnt_r  <= 3'h0;
         sr_r       <= 8'h00;
         tx_r       <= 8'h00;
         addr_r     <= '0;
         is_addr_r  <= 1'b0;
         rw_r       <= 1'b0;
         ack_on_r   <= 1'b0;
         oe_r       <= 1'b0;
         msg_tgl_r  <= 1'b0;
         msg_addr_r <= '0;
      end else if (ce_l) begin
         if (start_det) begin
            st_r      <= eer_pkg::ST_RX;
            bit_cnt_r <= 3'h0;
            is_addr_r <= 1'b0;
            ack_on_r  <= 1'b0;
            oe_r      <= 1'b0;
         end else if (stop_det) begin
            st_r     <= eer_pkg::ST_IDLE;
            ack_on_r <= 1'b0;
            oe_r     <= 1'b0;
         end else begin
            case (st_r)
               eer_pkg::ST_IDLE: begin
                  oe_r <= 1'b0;
               end
               eer_pkg::ST_RX: begin
                  if (scl_rise) begin
                     sr_r      <= full_byte;
                     bit_cnt_r <= bit_cnt_r + 3'h1;
                     if (bit_cnt_r == 3'h7) begin
                        if (is_addr_r) begin
                           addr_r     <= full_byte;
                           msg_addr_r <= full_byte;
                           msg_tgl_r  <= !msg_tgl_r;
                           st_r       <= eer_pkg::ST_ACK;
                        end else if (full_byte[7:1] == DEV_ADDR) begin
                           rw_r <= full_byte[0];
                           st_r <= eer_pkg::ST_ACK;
                        end else begin
                           st_r <= eer_pkg::ST_IDLE;
                        end
                     end
                  end
               end
               eer_pkg::ST_ACK: begin
                  if (scl_fall) begin
                     if (!ack_on_r) begin
                        ack_on_r <= 1'b1;
                        oe_r     <= 1'b1;
                     end else begin
                        ack_on_r  <= 1'b0;
                        bit_cnt_r <= 3'h0;
                        if (is_addr_r) begin
                           // Write data is not taken; later bytes go unanswered
                           oe_r <= 1'b0;
                           st_r <= eer_pkg::ST_IDLE;
                        end else if (rw_r) begin
                           tx_r <= load_byte;
                           oe_r <= !load_byte[7];
                           st_r <= eer_pkg::ST_TX;
                        end else begin
                           oe_r      <= 1'b0;
                           is_addr_r <= 1'b1;
                           st_r      <= eer_pkg::ST_RX;
                        end
                     end
                  end
               end
               eer_pkg::ST_TX: begin
                  if (scl_fall) begin
                     tx_r <= {tx_r[6:0], 1'b0};
                     oe_r <= !tx_r[6];
                  end else if (scl_rise) begin
                     bit_cnt_r <= bit_cnt_r + 3'h1;
                     if (bit_cnt_r == 3'h7) begin
                        st_r <= eer_pkg::ST_REL;
                     end
                  end
               end
               eer_pkg::ST_REL: begin
                  if (scl_fall) begin
                     oe_r   <= 1'b0;
                     addr_r <= addr_r + ADDR_ONE;
                     st_r   <= eer_pkg::ST_MACK;
                  end
               end
               eer_pkg::ST_MACK: begin
                  if (scl_rise) begin
                     if (!sda_s2_r) begin
                        st_r <= eer_pkg::ST_LOAD;
                     end else begin
                        st_r <= eer_pkg::ST_IDLE;
                     end
                  end
               end
               eer_pkg::ST_LOAD: begin
                  if (scl_fall) begin
                     tx_r      <= load_byte;
                     oe_r      <= !load_byte[7];
                     bit_cnt_r <= 3'h0;
                     st_r      <= eer_pkg::ST_TX;
                  end
               end
               default: begin
                  st_r <= eer_pkg::ST_IDLE;
                  oe_r <= 1'b0;
               end
            endcase
         end
      end
   end

   a_start_entry: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
      ce_l && start_det |=> st_r == eer_pkg::ST_RX && bit_cnt_r == 3'h0 && !oe_r)
      else $error("START did not restart reception");

   a_stop_idle: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
      ce_l && stop_det && !start_det |=> st_r == eer_pkg::ST_IDLE && !oe_r)
      else $error("STOP did not return to idle");

   a_addr_store: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
      ev_ok && st_r == eer_pkg::ST_RX && is_addr_r && scl_rise && bit_cnt_r == 3'h7
      |=> addr_r == $past(full_byte) && msg_tgl_r != $past(msg_tgl_r))
      else $error("Word address not stored");

   a_foreign_ignore: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
      ev_ok && st_r == eer_pkg::ST_RX && !is_addr_r && scl_rise && bit_cnt_r == 3'h7
      && full_byte[7:1] != DEV_ADDR |=> st_r == eer_pkg::ST_IDLE ##1 !oe_r)
      else $error("Foreign address answered");

   a_ack_drive: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
      ev_ok && st_r == eer_pkg::ST_ACK && !ack_on_r && scl_fall |=> oe_r && ack_on_r)
      else $error("Received byte not acknowledged");

   a_oe_on_fall: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
      $changed(oe_r) |-> $past(scl_fall || start_det || stop_det))
      else $error("Data drive changed away from a falling clock");

   a_first_byte: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
      ev_ok && st_r == eer_pkg::ST_ACK && ack_on_r && !is_addr_r && rw_r && scl_fall
      && head_ok |=> st_r == eer_pkg::ST_TX && tx_r == $past(head.data)
      && oe_r == !$past(head.data[7]))
      else $error("First byte not from loaded address");

   a_ninth_release: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
      ev_ok && st_r == eer_pkg::ST_REL && scl_fall |=> !oe_r && st_r == eer_pkg::ST_MACK)
      else $error("Data line not released for master acknowledge");

   a_addr_incr: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
      ev_ok && st_r == eer_pkg::ST_REL && scl_fall |=> addr_r == $past(addr_r) + ADDR_ONE)
      else $error("Address did not step after a byte");

   a_mack_next: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
      ev_ok && st_r == eer_pkg::ST_MACK && scl_rise && !sda_s2_r |=> st_r == eer_pkg::ST_LOAD)
      else $error("Acknowledged read did not continue");

   a_nack_quiet: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
      ev_ok && st_r == eer_pkg::ST_MACK && scl_rise && sda_s2_r
      |=> st_r == eer_pkg::ST_IDLE && !oe_r ##1 !oe_r)
      else $error("Transmission went on after no acknowledge");

   a_addr_kept: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
      st_r == eer_pkg::ST_IDLE |=> $stable(addr_r))
      else $error("Address changed while idle");
endmodule : eer_i2c_read

//--- rtl/eer_cfg.svh
// Fixed values of the serial read-path blocks
`ifndef EER_CFG_SVH
`define EER_CFG_SVH
`define EER_DEV_ADDR   7'h50
`define EER_ADDR_W     8
`define EER_MEM_DEPTH  256
`define EER_FIFO_DEPTH 8
`define EER_ERASED     8'hFF
`endif

//--- rtl/eer_pkg.sv
// Types shared by the serial read-path blocks
`include "eer_cfg.svh"
package eer_pkg;
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_RX   = 7'h02,
      ST_ACK  = 7'h04,
      ST_TX   = 7'h08,
      ST_REL  = 7'h10,
      ST_MACK = 7'h20,
      ST_LOAD = 7'h40
   } eer_state_e;

   typedef struct packed {
      logic [`EER_ADDR_W-1:0] tag;
      logic [7:0]             data;
   } eer_word_s;
endpackage : eer_pkg

//--- rtl/eer_fifo_if.sv
// Valid/ready carrier between the fetcher, the FIFO and the bus engine
`timescale 1ns/100ps
interface eer_fifo_if #(parameter int W = 16);
   logic         w_valid;
   logic         w_ready;
   logic [W-1:0] w_data;
   logic         r_valid;
   logic         r_ready;
   logic [W-1:0] r_data;

   modport fifo (input w_valid, input w_data, output w_ready,
                 output r_valid, output r_data, input r_ready);
   modport src  (output w_valid, output w_data, input w_ready);
   modport snk  (input r_valid, input r_data, output r_ready);
endinterface : eer_fifo_if

//--- rtl/eer_mem.sv
// Byte array with registered read data
`timescale 1ns/100ps
`include "eer_cfg.svh"
module eer_mem #(
   parameter int DEPTH = `EER_MEM_DEPTH,
   parameter int AW    = `EER_ADDR_W
) (
   input  wire logic          clk_i,
   input  wire logic          resetn_i,
   input  wire logic          ce_i,
   input  wire logic          we_i,
   input  wire logic [AW-1:0] waddr_i,
   input  wire logic [7:0]    wdata_i,
   input  wire logic          re_i,
   input  wire logic [AW-1:0] raddr_i,
   output logic      [7:0]    rdata_o
);
   localparam int IW = $clog2(DEPTH);

   logic [7:0] cell_r [DEPTH];

   // Delivered erased
   initial begin
      for (int i = 0; i < DEPTH; i++) begin
         cell_r[i] = `EER_ERASED;
      end
   end

   // Upper address bits fold onto the array when it is smaller than the counter
   always_ff @(posedge clk_i) begin
      if (ce_i && we_i) begin
         cell_r[waddr_i[IW-1:0]] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_o <= `EER_ERASED;
      end else if (ce_i && re_i) begin
         rdata_o <= cell_r[raddr_i[IW-1:0]];
      end
   end
endmodule : eer_mem

//--- rtl/eer_afifo.sv
// Dual-clock FIFO with gray-coded pointers
`timescale 1ns/100ps
module eer_afifo #(
   parameter int W     = 16,
   parameter int DEPTH = 8
) (
   input  wire logic wclk_i,
   input  wire logic rclk_i,
   input  wire logic resetn_i,
   input  wire logic wce_i,
   input  wire logic rce_i,
   eer_fifo_if.fifo  q
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] PTR_ONE = {{AW{1'b0}}, 1'b1};

   logic [W-1:0] slot_r [DEPTH];
   logic [AW:0]  wbin_r;
   logic [AW:0]  wgray_r;
   logic [AW:0]  rbin_r;
   logic [AW:0]  rgray_r;
   logic [AW:0]  rg_s1_r;
   logic [AW:0]  rg_s2_r;
   logic [AW:0]  wg_s1_r;
   logic [AW:0]  wg_s2_r;
   logic [AW:0]  wbin_nxt;
   logic [AW:0]  rbin_nxt;
   logic         full;
   logic         empty;
   logic         push;
   logic         pop;

   assign wbin_nxt  = wbin_r + PTR_ONE;
   assign rbin_nxt  = rbin_r + PTR_ONE;
   assign full      = (wgray_r == {~rg_s2_r[AW:AW-1], rg_s2_r[AW-2:0]});
   assign empty     = (rgray_r == wg_s2_r);
   assign push      = wce_i && q.w_valid && !full;
   assign pop       = rce_i && q.r_ready && !empty;
   assign q.w_ready = !full;
   assign q.r_valid = !empty;
   assign q.r_data  = slot_r[rbin_r[AW-1:0]];

   always_ff @(posedge wclk_i) begin
      if (push) begin
         slot_r[wbin_r[AW-1:0]] <= q.w_data;
      end
   end

   always_ff @(posedge wclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wbin_r  <= '0;
         wgray_r <= '0;
         rg_s1_r <= '0;
         rg_s2_r <= '0;
      end else if (wce_i) begin
         if (push) begin
            wbin_r  <= wbin_nxt;
            wgray_r <= wbin_nxt ^ (wbin_nxt >> 1);
         end
         rg_s1_r <= rgray_r;
         rg_s2_r <= rg_s1_r;
      end
   end

   always_ff @(posedge rclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rbin_r  <= '0;
         rgray_r <= '0;
         wg_s1_r <= '0;
         wg_s2_r <= '0;
      end else if (rce_i) begin
         if (pop) begin
            rbin_r  <= rbin_nxt;
            rgray_r <= rbin_nxt ^ (rbin_nxt >> 1);
         end
         wg_s1_r <= wgray_r;
         wg_s2_r <= wg_s1_r;
      end
   end
endmodule : eer_afifo

//--- dv/eer_master.sv
// Behavioural two-wire bus master that drives the read-path slave
`timescale 1ns/100ps
module eer_master (
   input  wire logic link_clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_oe_o
);
   initial begin
      scl_o    = 1'b1;
      sda_oe_o = 1'b0;
   end

   // Steps on link edges so every phase spans 4 link cycles or more
   task automatic tick(input int n);
      repeat (n) @(posedge link_clk_i);
      #1;
   endtask : tick

   // One clock pulse: data set while low, sampled in mid high phase
   task automatic bit_io(input logic b, output logic s);
      sda_oe_o = ~b;
      tick(4);
      scl_o = 1'b1;
      tick(4);
      s = sda_i;
      tick(4);
      scl_o = 1'b0;
      tick(4);
   endtask : bit_io

   // Also serves as repeated start: data released while clock low
   task automatic start();
      sda_oe_o = 1'b0;
      tick(4);
      scl_o = 1'b1;
      tick(4);
      sda_oe_o = 1'b1;
      tick(4);
      scl_o = 1'b0;
      tick(4);
   endtask : start

   task automatic stop();
      sda_oe_o = 1'b1;
      tick(4);
      scl_o = 1'b1;
      tick(4);
      sda_oe_o = 1'b0;
      tick(8);
   endtask : stop

   // Write byte: tx data, ack_in 1. Read byte: tx FFh, ack_in 0 for ACK, 1 for NACK
   task automatic xfer(input logic [7:0] tx, input logic ack_in,
                       output logic [7:0] rx, output logic ack_seen);
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      bit_io(ack_in, ack_seen);
   endtask : xfer
endmodule : eer_master

//--- dv/eer_tb.sv
// Self-checking bench for the serial read-path slave
`timescale 1ns/100ps
module tb;
   logic       ref_clk_i;
   logic       link_clk_i;
   logic       resetn_i;
   logic       pre_we_i;
   logic [7:0] pre_addr_i;
   logic [7:0] pre_data_i;
   logic       sda_o;
   logic       dev_oe;
   logic       scl;
   logic       m_oe;
   wire  logic sda = ~(dev_oe | m_oe);
   int         miscompares;
   int         cmp_count;

   eer_i2c_read eer_i2c_read_inst (
      .ref_clk_i  (ref_clk_i),
      .resetn_i   (resetn_i),
      .ce_i       (1'b1),
      .link_clk_i (link_clk_i),
      .scl_i      (scl),
      .sda_i      (sda),
      .pre_we_i   (pre_we_i),
      .pre_addr_i (pre_addr_i),
      .pre_data_i (pre_data_i),
      .sda_o      (sda_o),
      .sda_oe_o   (dev_oe)
   );

   eer_master eer_master_inst (
      .link_clk_i (link_clk_i),
      .sda_i      (sda),
      .scl_o      (scl),
      .sda_oe_o   (m_oe)
   );

   initial ref_clk_i = 1'b0;
   always #5 ref_clk_i = ~ref_clk_i;
   initial link_clk_i = 1'b0;
   always #24 link_clk_i = ~link_clk_i;

   // Stored pattern: distinct from the erased value at every address but A5h
   function automatic logic [7:0] pat(input logic [7:0] a);
      return a ^ 8'h5A;
   endfunction : pat

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude

   task automatic addr_load(input logic [7:0] a);
      logic [7:0] r;
      logic       k;
      eer_master_inst.start();
      eer_master_inst.xfer(8'hA0, 1'b1, r, k);
      check({7'h00, k}, 8'h00);
      eer_master_inst.xfer(a, 1'b1, r, k);
      check({7'h00, k}, 8'h00);
   endtask : addr_load

   // Start, read address, n bytes with ACK on all but the last, then STOP
   task automatic read_seq(input logic [7:0] first, input int n);
      logic [7:0] r;
      logic       k;
      eer_master_inst.start();
      eer_master_inst.xfer(8'hA1, 1'b1, r, k);
      check({7'h00, k}, 8'h00);
      for (int i = 0; i < n; i++) begin
         eer_master_inst.xfer(8'hFF, (i == n - 1), r, k);
         check(r, pat(first + i[7:0]));
      end
      check({7'h00, dev_oe}, 8'h00);
      check({7'h00, sda_o}, 8'h00);
      eer_master_inst.stop();
   endtask : read_seq

   task automatic sc_selective();
      addr_load(8'h10);
      read_seq(8'h10, 3);
   endtask : sc_selective

   task automatic sc_wrap();
      addr_load(8'hFE);
      read_seq(8'hFE, 3);
   endtask : sc_wrap

   // Immediate read continues after the last byte of the wrapped read
   task automatic sc_continue();
      read_seq(8'h01, 2);
   endtask : sc_continue

   task automatic sc_foreign();
      logic [7:0] r;
      logic       k;
      eer_master_inst.start();
      eer_master_inst.xfer(8'hA2, 1'b1, r, k);
      check({7'h00, k}, 8'h01);
      eer_master_inst.start();
      eer_master_inst.xfer(8'hB0, 1'b1, r, k);
      check({7'h00, k}, 8'h01);
      eer_master_inst.stop();
   endtask : sc_foreign

   // Data after the word address is refused, yet the address holds
   task automatic sc_data_after_addr();
      logic [7:0] r;
      logic       k;
      addr_load(8'h40);
      eer_master_inst.xfer(8'h77, 1'b1, r, k);
      check({7'h00, k}, 8'h01);
      eer_master_inst.stop();
      read_seq(8'h40, 2);
   endtask : sc_data_after_addr

   initial begin
      miscompares = 0;
      cmp_count   = 0;
      resetn_i    = 1'b0;
      pre_we_i    = 1'b0;
      pre_addr_i  = 8'h00;
      pre_data_i  = 8'h00;
      repeat (12) @(posedge ref_clk_i);
      #1;
      resetn_i = 1'b1;
      for (int i = 0; i < 256; i++) begin
         @(posedge ref_clk_i);
         #1;
         pre_we_i   = 1'b1;
         pre_addr_i = i[7:0];
         pre_data_i = pat(i[7:0]);
      end
      @(posedge ref_clk_i);
      #1;
      pre_we_i = 1'b0;
      repeat (40) @(posedge ref_clk_i);
      sc_selective();
      sc_wrap();
      sc_continue();
      sc_foreign();
      sc_data_after_addr();
      conclude();
   end

   // Hang guard: far beyond the longest expected run
   initial begin
      #600000;
      miscompares++;
      conclude();
   end
endmodule : tb
